// [include/timer16_regs.svh]
// Register offsets, field positions, reset values and fixed tops
// Contract
// - Counter seen as high and low byte
// - High-byte counter access goes to latch
// - Low read loads latch; low write commits
// - Tick clears, increments or decrements counter
// - Clock-select field picks tick source
// - Clock-select zero stops the counter
// - Counter readable and writable while stopped
// - CPU write beats clear and count
// - Waveform mode field sets count sequence
// - Overflow flag set per mode, interrupt capable
// - Qualified edge copies counter into capture
// - Capture flag set with the copy
// - Enabled capture flag interrupts, cleared on service
// - Writing one clears the capture flag
// - Capture low read first loads latch
// - Capture writable only in capture-top modes
// - Latch survives low-byte writes
// - Only low-byte access moves 16 bits
// - Compare high byte read directly
// - Bottom is 0x0000, max is 0xffff
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

`define OFS_CTRL_A 6'h00
`define OFS_CTRL_B 6'h01
`define OFS_CNT_LO 6'h02
`define OFS_CNT_HI 6'h03
`define OFS_CMPA_LO 6'h04
`define OFS_CMPA_HI 6'h05
`define OFS_CMPB_LO 6'h06
`define OFS_CMPB_HI 6'h07
`define OFS_CAP_LO 6'h08
`define OFS_CAP_HI 6'h09
`define OFS_FLAGS 6'h0a
`define OFS_MASK 6'h0b

`define BIT_OVF 0
`define BIT_CAP 1
`define BIT_EDGE_RISE 6
`define FLD_CS_MSB 2
`define FLD_CS_LSB 0
`define FLD_WGM_HI_MSB 4
`define FLD_WGM_HI_LSB 3
`define FLD_WGM_LO_MSB 1
`define FLD_WGM_LO_LSB 0

`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define CNT_BOTTOM 16'h0000
`define CNT_MAX 16'hffff
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff

`endif

// [include/timer16_pkg.sv]
// Types shared by the timer and its verification models
package timer16_pkg;

  typedef struct packed {
    logic [5:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } cpu_req_s;

  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } count_dir_e;

  typedef enum logic [1:0] {
    SEQ_NORMAL = 2'b00,
    SEQ_CTC = 2'b01,
    SEQ_FAST = 2'b10,
    SEQ_DUAL = 2'b11
  } count_seq_e;

  typedef enum logic [1:0] {
    TOP_FIXED_MAX = 2'b00,
    TOP_FIXED_SMALL = 2'b01,
    TOP_CMPA = 2'b10,
    TOP_CAP = 2'b11
  } top_src_e;

endpackage

// [rtl/input_sync_edge.sv]
// Two-stage synchronisers with edge detection for pin inputs
`timescale 1ns/100ps
module input_sync_edge #(
  parameter int N = 3
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [N-1:0] pins,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      // Per-pin flops so each process owns its own state
      logic meta_reg;
      logic sync_reg;
      logic last_reg;
      // First stage feeds only the second stage
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
          last_reg <= 1'b0;
        end else begin
          meta_reg <= pins[i];
          sync_reg <= meta_reg;
          last_reg <= sync_reg;
        end
      end
      assign rise[i] = sync_reg & ~last_reg;
      assign fall[i] = ~sync_reg & last_reg;
    end
  endgenerate

endmodule

// [rtl/timer16_counter_capture_access.sv]
// 16-bit timer/counter with input capture and byte-wide CPU access
`timescale 1ns/100ps
`include "timer16_regs.svh"
module timer16_counter_capture_access
  import timer16_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire cpu_req_s io_req,
  output logic [7:0] io_rdata,
  input wire logic [3:0] prescale_taps,
  input wire logic ext_clk_pin,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic capture_src_sel,
  input wire logic overflow_irq_ack,
  input wire logic capture_irq_ack,
  output logic overflow_irq,
  output logic capture_irq,
  output logic at_bottom,
  output logic at_max
);

  localparam int PIN_EXT = 0;
  localparam int PIN_CAP = 1;
  localparam int PIN_CMP = 2;

  // Register state
  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_a_next;
  logic [7:0] ctrl_b_reg;
  logic [7:0] ctrl_b_next;
  logic [7:0] temp_reg;
  logic [7:0] temp_next;
  logic [15:0] timer_count_value_reg;
  logic [15:0] timer_count_value_next;
  logic [15:0] capture_value_reg;
  logic [15:0] capture_value_next;
  logic [15:0] cmpa_reg;
  logic [15:0] cmpa_next;
  logic [15:0] cmpb_reg;
  logic [15:0] cmpb_next;
  logic overflow_flag_reg;
  logic overflow_flag_next;
  logic capture_flag_reg;
  logic capture_flag_next;
  logic overflow_irq_enable_reg;
  logic overflow_irq_enable_next;
  logic capture_irq_enable_reg;
  logic capture_irq_enable_next;
  count_dir_e dir_reg;
  count_dir_e dir_next;
  logic [7:0] rdata_next;

  // Decoded access strobes
  logic wr;
  logic rd;
  logic [7:0] wd;
  logic sel_cnt_lo;
  logic sel_cap_lo;
  logic cnt_lo_wr;
  logic cnt_lo_rd;
  logic cap_lo_rd;
  logic cap_lo_wr;
  logic hi_wr;

  // Mode decode
  logic [2:0] clock_select_field;
  logic [3:0] waveform_mode_field;
  count_seq_e seq;
  top_src_e top_src;
  logic [15:0] top_small;
  logic [15:0] top;
  logic cap_is_top;

  // Events
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic timer_tick;
  logic tov_set;
  logic cap_event;
  logic src_rise;
  logic src_fall;

  input_sync_edge #(
    .N(3)
  ) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pins({comparator_output, capture_pin, ext_clk_pin}),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign wr = io_req.wr;
  assign rd = io_req.rd;
  assign wd = io_req.wdata;
  assign sel_cnt_lo = (io_req.addr == `OFS_CNT_LO);
  assign sel_cap_lo = (io_req.addr == `OFS_CAP_LO);
  assign cnt_lo_wr = wr && sel_cnt_lo;
  assign cnt_lo_rd = rd && sel_cnt_lo;
  assign cap_lo_rd = rd && sel_cap_lo;
  assign cap_lo_wr = wr && sel_cap_lo && cap_is_top;
  // Every high-byte location writes the one shared latch
  assign hi_wr = wr && ((io_req.addr == `OFS_CNT_HI) || (io_req.addr == `OFS_CAP_HI) ||
    (io_req.addr == `OFS_CMPA_HI) || (io_req.addr == `OFS_CMPB_HI));

  assign clock_select_field = ctrl_b_reg[`FLD_CS_MSB:`FLD_CS_LSB];
  assign waveform_mode_field = {ctrl_b_reg[`FLD_WGM_HI_MSB:`FLD_WGM_HI_LSB],
    ctrl_a_reg[`FLD_WGM_LO_MSB:`FLD_WGM_LO_LSB]};

  // Count sequence and top source for each waveform mode
  always_comb begin
    seq = SEQ_NORMAL;
    top_src = TOP_FIXED_MAX;
    top_small = `CNT_MAX;
    case (waveform_mode_field[1:0])
      2'b01: top_small = `TOP_8BIT;
      2'b10: top_small = `TOP_9BIT;
      2'b11: top_small = `TOP_10BIT;
      default: top_small = `CNT_MAX;
    endcase
    case (waveform_mode_field)
      4'h0: begin
        seq = SEQ_NORMAL;
        top_src = TOP_FIXED_MAX;
      end
      4'h1, 4'h2, 4'h3: begin
        seq = SEQ_DUAL;
        top_src = TOP_FIXED_SMALL;
      end
      4'h4: begin
        seq = SEQ_CTC;
        top_src = TOP_CMPA;
      end
      4'h5, 4'h6, 4'h7: begin
        seq = SEQ_FAST;
        top_src = TOP_FIXED_SMALL;
      end
      4'h8, 4'ha: begin
        seq = SEQ_DUAL;
        top_src = TOP_CAP;
      end
      4'h9, 4'hb: begin
        seq = SEQ_DUAL;
        top_src = TOP_CMPA;
      end
      4'hc: begin
        seq = SEQ_CTC;
        top_src = TOP_CAP;
      end
      4'he: begin
        seq = SEQ_FAST;
        top_src = TOP_CAP;
      end
      4'hf: begin
        seq = SEQ_FAST;
        top_src = TOP_CMPA;
      end
      default: begin
        seq = SEQ_NORMAL;
        top_src = TOP_FIXED_MAX;
      end
    endcase
  end

  always_comb begin
    case (top_src)
      TOP_FIXED_SMALL: top = top_small;
      TOP_CMPA: top = cmpa_reg;
      TOP_CAP: top = capture_value_reg;
      default: top = `CNT_MAX;
    endcase
  end

  assign cap_is_top = (top_src == TOP_CAP);

  // Tick source; zero selects nothing so the counter holds
  always_comb begin
    case (clock_select_field)
      3'h0: timer_tick = 1'b0;
      3'h1: timer_tick = 1'b1;
      3'h2: timer_tick = prescale_taps[0];
      3'h3: timer_tick = prescale_taps[1];
      3'h4: timer_tick = prescale_taps[2];
      3'h5: timer_tick = prescale_taps[3];
      3'h6: timer_tick = pin_fall[PIN_EXT];
      3'h7: timer_tick = pin_rise[PIN_EXT];
      default: timer_tick = 1'b0;
    endcase
  end

  // Capture source and edge; input idle while capture defines top
  assign src_rise = capture_src_sel ? pin_rise[PIN_CMP] : pin_rise[PIN_CAP];
  assign src_fall = capture_src_sel ? pin_fall[PIN_CMP] : pin_fall[PIN_CAP];
  assign cap_event = ~cap_is_top &&
    (ctrl_b_reg[`BIT_EDGE_RISE] ? src_rise : src_fall);

  // Counter next value
  always_comb begin
    timer_count_value_next = timer_count_value_reg;
    dir_next = dir_reg;
    tov_set = 1'b0;
    if (timer_tick) begin
      if (seq == SEQ_DUAL) begin
        if (dir_reg == DIR_UP) begin
          if (timer_count_value_reg >= top) begin
            dir_next = DIR_DOWN;
            timer_count_value_next = timer_count_value_reg - 16'h0001;
          end else begin
            timer_count_value_next = timer_count_value_reg + 16'h0001;
          end
        end else if (timer_count_value_reg == `CNT_BOTTOM) begin
          dir_next = DIR_UP;
          timer_count_value_next = timer_count_value_reg + 16'h0001;
          tov_set = 1'b1;
        end else begin
          timer_count_value_next = timer_count_value_reg - 16'h0001;
        end
      end else begin
        dir_next = DIR_UP;
        if (timer_count_value_reg == top) begin
          timer_count_value_next = `CNT_BOTTOM;
        end else begin
          timer_count_value_next = timer_count_value_reg + 16'h0001;
        end
        if (seq == SEQ_FAST) begin
          tov_set = (timer_count_value_reg == top);
        end else begin
          tov_set = (timer_count_value_reg == `CNT_MAX);
        end
      end
    end
    // A low-byte counter write wins over the tick in the same cycle
    if (cnt_lo_wr) begin
      timer_count_value_next = {temp_reg, wd};
    end
  end

  // Shared high-byte latch
  always_comb begin
    temp_next = temp_reg;
    if (hi_wr) begin
      temp_next = wd;
    end else if (cnt_lo_rd) begin
      temp_next = timer_count_value_reg[15:8];
    end else if (cap_lo_rd) begin
      temp_next = capture_value_reg[15:8];
    end
  end

  // Capture, compare and control registers
  always_comb begin
    capture_value_next = capture_value_reg;
    cmpa_next = cmpa_reg;
    cmpb_next = cmpb_reg;
    ctrl_a_next = ctrl_a_reg;
    ctrl_b_next = ctrl_b_reg;
    overflow_irq_enable_next = overflow_irq_enable_reg;
    capture_irq_enable_next = capture_irq_enable_reg;
    if (cap_event) begin
      capture_value_next = timer_count_value_reg;
    end
    if (cap_lo_wr) begin
      capture_value_next = {temp_reg, wd};
    end
    if (wr && io_req.addr == `OFS_CMPA_LO) begin
      cmpa_next = {temp_reg, wd};
    end
    if (wr && io_req.addr == `OFS_CMPB_LO) begin
      cmpb_next = {temp_reg, wd};
    end
    if (wr && io_req.addr == `OFS_CTRL_A) begin
      ctrl_a_next = wd;
    end
    if (wr && io_req.addr == `OFS_CTRL_B) begin
      ctrl_b_next = wd;
    end
    if (wr && io_req.addr == `OFS_MASK) begin
      overflow_irq_enable_next = wd[`BIT_OVF];
      capture_irq_enable_next = wd[`BIT_CAP];
    end
  end

  // Flags: a set in the clearing cycle survives
  always_comb begin
    logic w1c_ovf;
    logic w1c_cap;
    w1c_ovf = wr && io_req.addr == `OFS_FLAGS && wd[`BIT_OVF];
    w1c_cap = wr && io_req.addr == `OFS_FLAGS && wd[`BIT_CAP];
    overflow_flag_next = tov_set ||
      (overflow_flag_reg && !(w1c_ovf || overflow_irq_ack));
    capture_flag_next = cap_event ||
      (capture_flag_reg && !(w1c_cap || capture_irq_ack));
  end

  // Read data, registered; high-byte counter and capture come from the latch
  always_comb begin
    rdata_next = 8'h00;
    if (rd) begin
      case (io_req.addr)
        `OFS_CTRL_A: rdata_next = ctrl_a_reg;
        `OFS_CTRL_B: rdata_next = ctrl_b_reg;
        `OFS_CNT_LO: rdata_next = timer_count_value_reg[7:0];
        `OFS_CNT_HI: rdata_next = temp_reg;
        `OFS_CMPA_LO: rdata_next = cmpa_reg[7:0];
        `OFS_CMPA_HI: rdata_next = cmpa_reg[15:8];
        `OFS_CMPB_LO: rdata_next = cmpb_reg[7:0];
        `OFS_CMPB_HI: rdata_next = cmpb_reg[15:8];
        `OFS_CAP_LO: rdata_next = capture_value_reg[7:0];
        `OFS_CAP_HI: rdata_next = temp_reg;
        `OFS_FLAGS: begin
          rdata_next[`BIT_OVF] = overflow_flag_reg;
          rdata_next[`BIT_CAP] = capture_flag_reg;
        end
        `OFS_MASK: begin
          rdata_next[`BIT_OVF] = overflow_irq_enable_reg;
          rdata_next[`BIT_CAP] = capture_irq_enable_reg;
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_a_reg <= `RST_BYTE;
      ctrl_b_reg <= `RST_BYTE;
      temp_reg <= `RST_BYTE;
      timer_count_value_reg <= `RST_WORD;
      capture_value_reg <= `RST_WORD;
      cmpa_reg <= `RST_WORD;
      cmpb_reg <= `RST_WORD;
      overflow_flag_reg <= 1'b0;
      capture_flag_reg <= 1'b0;
      overflow_irq_enable_reg <= 1'b0;
      capture_irq_enable_reg <= 1'b0;
      dir_reg <= DIR_UP;
      io_rdata <= 8'h00;
      overflow_irq <= 1'b0;
      capture_irq <= 1'b0;
      at_bottom <= 1'b1;
      at_max <= 1'b0;
    end else begin
      ctrl_a_reg <= ctrl_a_next;
      ctrl_b_reg <= ctrl_b_next;
      temp_reg <= temp_next;
      timer_count_value_reg <= timer_count_value_next;
      capture_value_reg <= capture_value_next;
      cmpa_reg <= cmpa_next;
      cmpb_reg <= cmpb_next;
      overflow_flag_reg <= overflow_flag_next;
      capture_flag_reg <= capture_flag_next;
      overflow_irq_enable_reg <= overflow_irq_enable_next;
      capture_irq_enable_reg <= capture_irq_enable_next;
      dir_reg <= dir_next;
      io_rdata <= rdata_next;
      // Requests track the flag and enable as they stand after this edge
      overflow_irq <= overflow_flag_next && overflow_irq_enable_next;
      capture_irq <= capture_flag_next && capture_irq_enable_next;
      at_bottom <= (timer_count_value_next == `CNT_BOTTOM);
      at_max <= (timer_count_value_next == `CNT_MAX);
    end
  end

endmodule

// [verification/cpu_model.sv]
// Behavioural CPU issuing byte accesses on the I/O bus
`timescale 1ns/100ps
module cpu_model
  import timer16_pkg::*;
(
  input wire logic sys_clk,
  output cpu_req_s io_req,
  input wire logic [7:0] io_rdata
);
  initial io_req = '0;
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    io_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge sys_clk) #1;
    io_req = '0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk) #1;
    io_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge sys_clk) #1;
    d = io_rdata;
    io_req = '0;
  endtask
  // No interrupts here, so nothing can touch the latch mid-pair
  task automatic wr16(input logic [5:0] a, input logic [15:0] v);
    wr(a + 6'h01, v[15:8]);
    wr(a, v[7:0]);
  endtask
  task automatic rd16(input logic [5:0] a, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a + 6'h01, hi);
    v = {hi, lo};
  endtask
endmodule

// [verification/timer16_asserts.sv]
// Port-level assertions for the 16-bit timer with capture
`timescale 1ns/100ps
`include "timer16_regs.svh"
module timer16_asserts
  import timer16_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire cpu_req_s io_req,
  input wire logic [7:0] io_rdata,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic capture_src_sel,
  input wire logic capture_irq_ack,
  input wire logic overflow_irq,
  input wire logic capture_irq,
  input wire logic at_bottom,
  input wire logic at_max
);
  logic [2:0] src_q;
  logic [2:0] quiet_cnt;
  logic [7:0] lat;
  logic lat_ok;
  logic [7:0] cmpa_hi;
  logic cmpa_ok;
  logic quiet;
  logic hi_wr;
  // Margin covers synchroniser plus edge flop plus capture
  assign quiet = (quiet_cnt == 3'd6);
  assign hi_wr = io_req.wr && io_req.addr[0] && io_req.addr >= `OFS_CNT_HI
    && io_req.addr <= `OFS_CAP_HI;
  always_ff @(posedge sys_clk) begin
    src_q <= {capture_pin, comparator_output, capture_src_sel};
    if (sys_rst || src_q != {capture_pin, comparator_output, capture_src_sel}) begin
      quiet_cnt <= 3'd0;
    end else if (!quiet) begin
      quiet_cnt <= quiet_cnt + 3'd1;
    end
    if (sys_rst) begin
      lat <= 8'h00;
      lat_ok <= 1'b1;
      cmpa_hi <= 8'h00;
      cmpa_ok <= 1'b1;
    end else begin
      if (hi_wr) begin
        lat <= io_req.wdata;
        lat_ok <= 1'b1;
      end else if (io_req.rd && (io_req.addr == `OFS_CNT_LO || io_req.addr == `OFS_CAP_LO)) begin
        lat_ok <= 1'b0;
      end
      if (io_req.wr && io_req.addr == `OFS_CMPA_LO) begin
        cmpa_hi <= lat;
        cmpa_ok <= lat_ok;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_cnt_commit;
    io_req.wr && io_req.addr == `OFS_CNT_LO && lat_ok;
  endsequence
  chk_reset_state: assert property (
    $fell(sys_rst) |-> at_bottom && !at_max && !capture_irq && !overflow_irq && io_rdata == 8'h00)
    else $error("outputs wrong after reset");
  chk_ends_apart: assert property (!(at_bottom && at_max))
    else $error("bottom and max together");
  chk_latch_read: assert property (
    io_req.rd && (io_req.addr == `OFS_CNT_HI || io_req.addr == `OFS_CAP_HI) && lat_ok
    |=> io_rdata == lat) else $error("high read not from latch");
  chk_cmp_direct: assert property (
    io_req.rd && io_req.addr == `OFS_CMPA_HI && cmpa_ok |=> io_rdata == cmpa_hi)
    else $error("compare high read wrong");
  chk_zero_commit: assert property (
    s_cnt_commit ##0 {lat, io_req.wdata} == `CNT_BOTTOM |-> ##[1:2] at_bottom)
    else $error("zero write not seen at bottom");
  chk_max_commit: assert property (
    s_cnt_commit ##0 {lat, io_req.wdata} == `CNT_MAX |-> ##[1:2] at_max)
    else $error("max write not seen at max");
  chk_cap_ack: assert property (capture_irq_ack && quiet |=> !capture_irq)
    else $error("service did not clear capture");
  chk_flag_w1c: assert property (
    io_req.wr && io_req.addr == `OFS_FLAGS && io_req.wdata[`BIT_CAP] && quiet |=> !capture_irq)
    else $error("write one did not clear capture");
  chk_no_edge: assert property (
    quiet && !(io_req.wr && io_req.addr == `OFS_MASK) |=> !$rose(capture_irq))
    else $error("capture without edge");
endmodule
bind timer16_counter_capture_access timer16_asserts chk_u (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .io_req(io_req), .io_rdata(io_rdata),
  .capture_pin(capture_pin), .comparator_output(comparator_output),
  .capture_src_sel(capture_src_sel), .capture_irq_ack(capture_irq_ack),
  .overflow_irq(overflow_irq), .capture_irq(capture_irq),
  .at_bottom(at_bottom), .at_max(at_max)
);

// [verification/timer16_counter_capture_access_tb.sv]
// Self-checking bench for the 16-bit timer with capture
`timescale 1ns/100ps
`include "timer16_regs.svh"
module timer16_counter_capture_access_tb
  import timer16_pkg::*;
;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  cpu_req_s io_req;
  logic [7:0] io_rdata;
  logic [3:0] prescale_taps = 4'h0;
  logic ext_clk_pin = 1'b0;
  logic capture_pin = 1'b0;
  logic comparator_output = 1'b0;
  logic capture_src_sel = 1'b0;
  logic overflow_irq_ack = 1'b0;
  logic capture_irq_ack = 1'b0;
  logic overflow_irq, capture_irq, at_bottom, at_max;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [15:0] v;
  logic [7:0] b;
  always #5 sys_clk = ~sys_clk;
  cpu_model cpu_u (.sys_clk(sys_clk), .io_req(io_req), .io_rdata(io_rdata));
  timer16_counter_capture_access dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .io_req(io_req), .io_rdata(io_rdata),
    .prescale_taps(prescale_taps), .ext_clk_pin(ext_clk_pin), .capture_pin(capture_pin),
    .comparator_output(comparator_output), .capture_src_sel(capture_src_sel),
    .overflow_irq_ack(overflow_irq_ack), .capture_irq_ack(capture_irq_ack),
    .overflow_irq(overflow_irq), .capture_irq(capture_irq),
    .at_bottom(at_bottom), .at_max(at_max));
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk) #1 prescale_taps[0] = 1'b1;
      @(posedge sys_clk) #1 prescale_taps[0] = 1'b0;
    end
  endtask
  task automatic flags(input logic [7:0] exp);
    cpu_u.rd(`OFS_FLAGS, b);
    chk("flags", {8'h00, b}, {8'h00, exp});
  endtask
  task automatic cnt(input logic [15:0] exp);
    cpu_u.rd16(`OFS_CNT_LO, v);
    chk("count", v, exp);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("MISMATCH timeout expected end seen hang");
      test_done;
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    chk("bottom", {15'h0, at_bottom}, 16'h0001);
    cnt(16'h0000);
    cpu_u.rd16(`OFS_CAP_LO, v);
    chk("capture", v, 16'h0000);
    flags(8'h00);
    cpu_u.rd(6'h20, b);
    chk("unmapped", {8'h00, b}, 16'h0000);
    $display("test reset done");
    cpu_u.wr16(`OFS_CNT_LO, 16'h01ff);
    repeat (10) @(posedge sys_clk);
    cnt(16'h01ff);
    cpu_u.wr(`OFS_CNT_HI, 8'h12);
    cpu_u.wr(`OFS_CNT_LO, 8'h34);
    cpu_u.wr(`OFS_CMPA_LO, 8'h56);
    cpu_u.wr(`OFS_CNT_HI, 8'h77);
    cpu_u.rd(`OFS_CNT_HI, b);
    chk("latch", {8'h00, b}, 16'h0077);
    cnt(16'h1234);
    cpu_u.rd(`OFS_CAP_LO, b);
    cpu_u.rd(`OFS_CMPA_HI, b);
    chk("compare high", {8'h00, b}, 16'h0012);
    $display("test access done");
    cpu_u.wr(`OFS_MASK, 8'h01);
    cpu_u.wr(`OFS_CTRL_B, 8'h02);
    cpu_u.wr16(`OFS_CNT_LO, 16'hffff);
    @(posedge sys_clk) #1;
    chk("max", {15'h0, at_max}, 16'h0001);
    tick(2);
    cnt(16'h0001);
    flags(8'h01);
    chk("ovf irq", {15'h0, overflow_irq}, 16'h0001);
    @(posedge sys_clk) #1 overflow_irq_ack = 1'b1;
    @(posedge sys_clk) #1 overflow_irq_ack = 1'b0;
    flags(8'h00);
    chk("ovf irq", {15'h0, overflow_irq}, 16'h0000);
    cpu_u.wr(`OFS_CNT_HI, 8'h00);
    fork
      cpu_u.wr(`OFS_CNT_LO, 8'h10);
      tick(1);
    join
    cnt(16'h0010);
    cpu_u.wr(`OFS_CTRL_A, 8'h01);
    cpu_u.wr16(`OFS_CNT_LO, 16'h00fe);
    tick(3);
    cnt(16'h00fd);
    cpu_u.wr(`OFS_CTRL_A, 8'h02);
    cpu_u.wr(`OFS_CTRL_B, 8'h1a);
    cpu_u.wr16(`OFS_CAP_LO, 16'h0003);
    cpu_u.wr16(`OFS_CNT_LO, 16'h0002);
    cpu_u.wr(`OFS_FLAGS, 8'h03);
    tick(2);
    cnt(16'h0000);
    flags(8'h01);
    cpu_u.wr(`OFS_CTRL_A, 8'h00);
    cpu_u.wr(`OFS_CTRL_B, 8'h0a);
    cpu_u.wr16(`OFS_CNT_LO, 16'h1255);
    cpu_u.wr(`OFS_FLAGS, 8'h01);
    tick(2);
    cnt(16'h0000);
    flags(8'h00);
    cpu_u.wr(`OFS_CTRL_B, 8'h00);
    cpu_u.wr16(`OFS_CAP_LO, 16'h0009);
    cpu_u.rd16(`OFS_CAP_LO, v);
    chk("capture", v, 16'h0003);
    $display("test counting done");
    cpu_u.wr(`OFS_FLAGS, 8'h03);
    cpu_u.wr16(`OFS_CNT_LO, 16'h4321);
    cpu_u.wr(`OFS_CTRL_B, 8'h40);
    cpu_u.wr(`OFS_MASK, 8'h02);
    capture_pin = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 chk("capture irq", {15'h0, capture_irq}, 16'h0001);
    flags(8'h02);
    cpu_u.rd16(`OFS_CAP_LO, v);
    chk("capture", v, 16'h4321);
    @(posedge sys_clk) #1 capture_irq_ack = 1'b1;
    @(posedge sys_clk) #1 capture_irq_ack = 1'b0;
    flags(8'h00);
    capture_pin = 1'b0;
    repeat (6) @(posedge sys_clk);
    flags(8'h00);
    capture_src_sel = 1'b1;
    repeat (6) @(posedge sys_clk);
    cpu_u.wr(`OFS_FLAGS, 8'h02);
    cpu_u.wr16(`OFS_CNT_LO, 16'h0777);
    comparator_output = 1'b1;
    repeat (6) @(posedge sys_clk);
    cpu_u.rd16(`OFS_CAP_LO, v);
    chk("capture", v, 16'h0777);
    cpu_u.wr(`OFS_FLAGS, 8'h02);
    flags(8'h00);
    $display("test capture done");
    cpu_u.wr16(`OFS_CNT_LO, 16'h0000);
    cpu_u.wr(`OFS_CTRL_B, 8'h07);
    repeat (2) begin
      ext_clk_pin = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 ext_clk_pin = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
    end
    cpu_u.wr(`OFS_CTRL_B, 8'h00);
    cnt(16'h0002);
    cpu_u.wr(`OFS_CTRL_B, 8'h06);
    ext_clk_pin = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 ext_clk_pin = 1'b0;
    repeat (4) @(posedge sys_clk);
    cpu_u.wr(`OFS_CTRL_B, 8'h00);
    cnt(16'h0003);
    $display("test external clock done");
    test_done;
  end
endmodule
